/* hw/pcars_top.sv */
/*
  Program counter, high-address holding latch and hardware return stack
  of a small 8-bit core, with an APB view of the software-visible parts.
  Assumes the core sequencer drives the control strobes on core_clk_in,
  at most one of jump, call, return and interrupt in any cycle.
*/
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pcars_top #(
  parameter int                  STACK_DEPTH = pcars_pkg::STACK_DEPTH,
  parameter logic [12:0]         IRQ_VECTOR  = pcars_pkg::IRQ_VECTOR
) (
  // Clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         srst_in,
  // APB slave
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [pcars_pkg::APB_AW-1:0] paddr_in,
  input  wire logic [pcars_pkg::APB_DW-1:0] pwdata_in,
  input  wire logic [3:0]                   pstrb_in,
  output logic                              pready_out,
  output logic      [pcars_pkg::APB_DW-1:0] prdata_out,
  output logic                              pslverr_out,
  // Core sequencer strobes
  input  wire logic                         fetch_adv_in,
  input  wire logic                         jump_in,
  input  wire logic                         call_in,
  input  wire logic [pcars_pkg::JUMP_W-1:0] target_in,
  input  wire logic                         ret_in,
  input  wire logic                         irq_in,
  // Core data-path writes
  input  wire logic                         core_low_wr_in,
  input  wire logic [pcars_pkg::LOW_W-1:0]  core_low_data_in,
  input  wire logic                         core_latch_wr_in,
  input  wire logic [pcars_pkg::LATCH_W-1:0] core_latch_data_in,
  // Counter and latch
  output logic      [pcars_pkg::PC_W-1:0]   program_counter_out,
  output logic      [pcars_pkg::LATCH_W-1:0] high_address_holding_latch_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [pcars_pkg::PC_W-1:0]    program_counter;
    logic [pcars_pkg::LATCH_W-1:0] high_address_holding_latch;
  } pcars_state_s;

  pcars_state_s                  st_q;
  pcars_state_s                  st_d;

  logic                          bus_wr;
  logic                          bus_rd;
  logic                          bus_hit;
  logic [pcars_pkg::APB_DW-1:0]  bus_rdata;
  logic                          wr_low;
  logic                          wr_latch;
  logic                          sw_low_wr;
  logic [pcars_pkg::LOW_W-1:0]   sw_low_data;
  logic                          sw_latch_wr;
  logic [pcars_pkg::LATCH_W-1:0] sw_latch_data;
  logic                          stk_push;
  logic                          stk_pop;
  logic [pcars_pkg::PC_W-1:0]    stk_top;
  logic [pcars_pkg::PC_W-1:0]    pc_next_seq;

  // ****************************************
  // Register bus
  // ****************************************
  pcars_apb #(
    .AW (pcars_pkg::APB_AW),
    .DW (pcars_pkg::APB_DW)
  ) u_apb (
    .clk_in      (core_clk_in),
    .srst_in     (srst_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .pready_out  (pready_out),
    .prdata_out  (prdata_out),
    .pslverr_out (pslverr_out),
    .rdata_in    (bus_rdata),
    .hit_in      (bus_hit),
    .wr_out      (bus_wr),
    .rd_out      (bus_rd)
  );

  // The status word is read only; writing it is refused with an error.
  // No offset reaches the stack or its pointer.
  always_comb
  begin
    bus_hit   = 1'b0;
    bus_rdata = '0;
    case (paddr_in)
      pcars_pkg::OFF_COUNTER_LOW:
      begin
        bus_hit   = 1'b1;
        bus_rdata = {24'h000000, st_q.program_counter[7:0]};
      end
      pcars_pkg::OFF_HOLD_LATCH:
      begin
        bus_hit   = 1'b1;
        bus_rdata = {27'h0000000, st_q.high_address_holding_latch};
      end
      pcars_pkg::OFF_PC_STATUS:
      begin
        bus_hit   = ~pwrite_in;
        bus_rdata = {19'h00000, st_q.program_counter};
      end
      default:
      begin
        bus_hit   = 1'b0;
        bus_rdata = '0;
      end
    endcase
  end

  // Upper counter bits have no write path of their own
  assign wr_low   = bus_wr & pstrb_in[0] & (paddr_in == pcars_pkg::OFF_COUNTER_LOW);
  assign wr_latch = bus_wr & pstrb_in[0] & (paddr_in == pcars_pkg::OFF_HOLD_LATCH);

  // Core data path and bus share one write port; the core wins a tie
  always_comb
  begin
    sw_low_wr     = core_low_wr_in | wr_low;
    sw_low_data   = core_low_wr_in ? core_low_data_in : pwdata_in[7:0];
    sw_latch_wr   = core_latch_wr_in | wr_latch;
    sw_latch_data = core_latch_wr_in ? core_latch_data_in : pwdata_in[4:0];
  end

  // ****************************************
  // Return stack
  // ****************************************
  pcars_stack #(
    .W     (pcars_pkg::PC_W),
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk_in       (core_clk_in),
    .srst_in      (srst_in),
    .push_in      (stk_push),
    .push_data_in (pc_next_seq),
    .pop_in       (stk_pop),
    .top_out      (stk_top)
  );

  // ****************************************
  // Counter update
  // ****************************************
  // Address that would be fetched next if nothing diverted the flow
  assign pc_next_seq = fetch_adv_in ?
                       pcars_pkg::PC_W'(st_q.program_counter + 13'h0001) :
                       st_q.program_counter;

  always_comb
  begin
    st_d     = st_q;
    stk_push = 1'b0;
    stk_pop  = 1'b0;
    st_d.program_counter = pc_next_seq;
    if (ret_in)
    begin
      stk_pop = 1'b1;
      st_d.program_counter = stk_top;
    end
    if (irq_in)
    begin
      // Interrupted flow resumes where it left off
      stk_push = 1'b1;
      stk_pop  = 1'b0;
      st_d.program_counter = IRQ_VECTOR;
    end
    if (jump_in | call_in)
    begin
      stk_push = call_in | irq_in;
      stk_pop  = 1'b0;
      st_d.program_counter = {st_q.high_address_holding_latch[4:3], target_in};
    end
    if (sw_low_wr)
    begin
      // Low-byte write ripples no carry into the upper bits, so
      // computed tables must not straddle a 256-word page
      st_d.program_counter = {st_q.high_address_holding_latch, sw_low_data};
    end
    // Stack traffic never touches the latch; only explicit writes do
    if (sw_latch_wr)
    begin
      st_d.high_address_holding_latch = sw_latch_data;
    end
    if (srst_in)
    begin
      st_d.program_counter            = pcars_pkg::PC_RESET;
      st_d.high_address_holding_latch = pcars_pkg::LATCH_RESET;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    st_q <= st_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign program_counter_out            = st_q.program_counter;
  assign high_address_holding_latch_out = st_q.high_address_holding_latch;

  // Bus read strobe has no side effect here; reads are pure
  logic unused_rd;
  assign unused_rd = bus_rd;

endmodule : pcars_top

`default_nettype wire

/* inc/pcars_pkg.sv */
/*
  Package for the program counter and return stack: widths, register
  offsets, reset values and the interrupt vector.
  Assumes a 32-bit APB register bus and one core clock.
*/
`default_nettype none

package pcars_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PC_W       = 13;
  localparam int LOW_W      = 8;
  localparam int LATCH_W    = 5;
  localparam int JUMP_W     = 11;
  localparam int STACK_DEPTH = 8;
  localparam int APB_AW     = 12;
  localparam int APB_DW     = 32;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [APB_AW-1:0] OFF_COUNTER_LOW = 12'h000;
  localparam logic [APB_AW-1:0] OFF_HOLD_LATCH  = 12'h004;
  localparam logic [APB_AW-1:0] OFF_PC_STATUS   = 12'h008;

  // ****************************************
  // Reset values and vectors
  // ****************************************
  localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
  localparam logic [PC_W-1:0]    IRQ_VECTOR  = 13'h0004;
  localparam logic [2:0]         SP_RESET    = 3'h0;

endpackage : pcars_pkg

`default_nettype wire

/* hw/pcars_stack.sv */
/*
  Circular return stack of fixed depth.
  Assumes push and pop are never requested together; push then wins.
*/
`timescale 1ns/1ps
`default_nettype none

module pcars_stack #(
  parameter int W     = 13,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  // Push and pop
  input  wire logic         push_in,
  input  wire logic [W-1:0] push_data_in,
  input  wire logic         pop_in,
  output logic      [W-1:0] top_out
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           sp;
  } pcars_stk_s;

  pcars_stk_s st_q;
  pcars_stk_s st_d;

  // Pointer names the next free slot; the top sits one below it
  assign top_out = st_q.mem[PW'(st_q.sp - PW'(1))];

  always_comb
  begin
    st_d = st_q;
    if (push_in)
    begin
      // Wraps silently: the ninth push lands on the first entry
      st_d.mem[st_q.sp] = push_data_in;
      st_d.sp           = PW'(st_q.sp + PW'(1));
    end
    else if (pop_in)
    begin
      // Underflow just wraps too, no flag anywhere
      st_d.sp = PW'(st_q.sp - PW'(1));
    end
    if (srst_in)
    begin
      st_d    = '0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    st_q <= st_d;
  end

endmodule : pcars_stack

`default_nettype wire

/* hw/pcars_apb.sv */
/*
  APB slave front end: one wait state, registered answer.
  Assumes the owner decodes the word and returns read data and a hit.
*/
`timescale 1ns/1ps
`default_nettype none

module pcars_apb #(
  parameter int AW = 12,
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          srst_in,
  // APB
  input  wire logic          psel_in,
  input  wire logic          penable_in,
  input  wire logic          pwrite_in,
  output logic               pready_out,
  output logic      [DW-1:0] prdata_out,
  output logic               pslverr_out,
  // Register side
  input  wire logic [DW-1:0] rdata_in,
  input  wire logic          hit_in,
  output logic               wr_out,
  output logic               rd_out
);

  typedef struct packed {
    logic          ready;
    logic          err;
    logic [DW-1:0] rdata;
  } pcars_apb_s;

  pcars_apb_s st_q;
  pcars_apb_s st_d;
  logic       access;

  assign access      = psel_in & penable_in;
  // Write commits only on the edge where the master sees pready
  assign wr_out      = access & st_q.ready & pwrite_in & hit_in;
  assign rd_out      = access & st_q.ready & ~pwrite_in;
  assign pready_out  = st_q.ready;
  assign prdata_out  = st_q.rdata;
  assign pslverr_out = st_q.err;

  always_comb
  begin
    st_d = st_q;
    st_d.ready = 1'b0;
    st_d.err   = 1'b0;
    // Read data stands only with pready, like the other answer bits
    st_d.rdata = '0;
    if (access & ~st_q.ready)
    begin
      st_d.ready = 1'b1;
      st_d.err   = ~hit_in;
      st_d.rdata = (hit_in & ~pwrite_in) ? rdata_in : '0;
    end
    if (srst_in)
    begin
      st_d = '0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    st_q <= st_d;
  end

endmodule : pcars_apb

`default_nettype wire

/* verif/pcars_props.sv */
/* Assertions on the ports of pcars_top.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none

module pcars_props #(
  parameter logic [12:0] IRQ_VECTOR = pcars_pkg::IRQ_VECTOR
) (
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        srst_in,
  // APB
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Sequencer and core data-path writes
  input wire logic        fetch_adv_in,
  input wire logic        jump_in,
  input wire logic        call_in,
  input wire logic [10:0] target_in,
  input wire logic        ret_in,
  input wire logic        irq_in,
  input wire logic        core_low_wr_in,
  input wire logic        core_latch_wr_in,
  // State
  input wire logic [12:0] program_counter_out,
  input wire logic [4:0]  high_address_holding_latch_out
);
  // ****************************************
  // Decode
  // ****************************************
  logic bus_wr, bus_low, bus_lat, ovr, jc;
  logic [12:0] pc;
  logic [4:0] lat;
  assign pc = program_counter_out;
  assign lat = high_address_holding_latch_out;
  assign bus_wr = psel_in & penable_in & pwrite_in & pready_out;
  assign bus_low = bus_wr & (paddr_in == 12'h000);
  assign bus_lat = bus_wr & (paddr_in == 12'h004);
  assign ovr = bus_low | core_low_wr_in;
  assign jc = jump_in | call_in;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  // ****************************************
  // Properties
  // ****************************************
  sequence s_call;
    call_in & ~(ovr | jump_in | fetch_adv_in);
  endsequence
  sequence s_ret;
    ret_in & ~(ovr | jc | irq_in);
  endsequence

  a_reset_clears: assert property (disable iff (1'b0) srst_in |=> pc == 13'h0000)
    else $error("counter not cleared by reset");
  a_fetch_step: assert property (fetch_adv_in & ~(ovr | jc | irq_in | ret_in)
    |=> pc == $past(pc) + 13'h0001) else $error("fetch did not step counter");
  a_low_write: assert property (bus_low & ~core_low_wr_in
    |=> pc == {$past(lat), $past(pwdata_in[7:0])}) else $error("low write load wrong");
  a_jump_top: assert property (jc & ~ovr
    |=> pc == {$past(lat[4:3]), $past(target_in)}) else $error("jump load wrong");
  a_irq_vector: assert property (irq_in & ~(ovr | jc) |=> pc == IRQ_VECTOR)
    else $error("interrupt vector wrong");
  a_call_return: assert property (s_call ##1 s_ret |=> pc == $past(pc, 2))
    else $error("return did not restore counter");
  a_latch_kept: assert property ((call_in | ret_in | irq_in) & ~core_latch_wr_in
    & ~bus_lat |=> $stable(lat)) else $error("latch moved on push or pop");
  a_one_wait: assert property (psel_in & penable_in & ~$past(penable_in)
    |-> ~pready_out ##1 pready_out) else $error("bus answer timing wrong");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
endmodule : pcars_props

bind pcars_top pcars_props #(.IRQ_VECTOR(IRQ_VECTOR)) u_props (.core_clk_in, .srst_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out,
  .fetch_adv_in, .jump_in, .call_in, .target_in, .ret_in, .irq_in, .core_low_wr_in,
  .core_latch_wr_in, .program_counter_out, .high_address_holding_latch_out);

`default_nettype wire

/* verif/pcars_seq_model.sv */
/* Model of the core sequencer: turns a command code into one strobe.
   Assumes the bench holds a code for exactly one clock per strobe. */
`timescale 1ns/1ps
`default_nettype none

module pcars_seq_model (
  // Clock and command
  input  wire logic        core_clk_in,
  input  wire logic [2:0]  op_in,
  input  wire logic [10:0] tgt_in,
  // Strobes
  output logic             fetch_adv_out,
  output logic             jump_out,
  output logic             call_out,
  output logic             ret_out,
  output logic             irq_out,
  output logic [10:0]      target_out
);
  always_ff @(posedge core_clk_in)
  begin
    fetch_adv_out <= (op_in == 3'h1);
    jump_out      <= (op_in == 3'h2);
    call_out      <= (op_in == 3'h3);
    ret_out       <= (op_in == 3'h4);
    irq_out       <= (op_in == 3'h5);
    // Target is junk outside jumps and calls so a stale value cannot pass
    target_out    <= (op_in inside {3'h2, 3'h3}) ? tgt_in : ~tgt_in;
  end
endmodule : pcars_seq_model

`default_nettype wire

/* verif/tb.sv */
/* Self-checking bench for pcars_top with the sequencer model.
   Core write ports stay idle except in t_core; elsewhere software reaches registers by APB. */
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        core_clk_in, srst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic        fetch_adv_in, jump_in, call_in, ret_in, irq_in, e;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [10:0] target_in, tgt;
  logic [2:0]  op;
  logic [12:0] program_counter_out, epc;
  logic [4:0]  high_address_holding_latch_out, core_latch_data_in;
  logic        core_low_wr_in, core_latch_wr_in;
  logic [7:0]  core_low_data_in;
  int          error_cnt, check_count, cyc, i;

  pcars_top dut (.core_clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in(4'hf), .pready_out, .prdata_out, .pslverr_out, .fetch_adv_in,
    .jump_in, .call_in, .target_in, .ret_in, .irq_in, .core_low_wr_in,
    .core_low_data_in, .core_latch_wr_in, .core_latch_data_in,
    .program_counter_out, .high_address_holding_latch_out);
  pcars_seq_model u_seq (.core_clk_in, .op_in(op), .tgt_in(tgt), .fetch_adv_out(fetch_adv_in),
    .jump_out(jump_in), .call_out(call_in), .ret_out(ret_in), .irq_out(irq_in),
    .target_out(target_in));

  initial
  begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    @(posedge core_clk_in);
    while (pready_out !== 1'b1)
      @(posedge core_clk_in);
    rd = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  // One code per clock; two idle codes let the counter settle
  task seq(input logic [2:0] c, input logic [10:0] t);
    op <= c;
    tgt <= t;
    @(posedge core_clk_in);
  endtask : seq

  task settle;
    seq(3'h0, 11'h000);
    seq(3'h0, 11'h000);
  endtask : settle

  task t_regs;
    chk(program_counter_out, 0);
    apb(1'b1, 12'h004, 32'h15);
    apb(1'b1, 12'h000, 32'ha7);
    // The write lands on the completing edge; look one edge later
    @(posedge core_clk_in);
    chk(program_counter_out, 32'h15a7);
    apb(1'b0, 12'h000, 0);
    chk(rd, 32'ha7);
    apb(1'b1, 12'h008, 0);
    chk(e, 1'b1);
    apb(1'b0, 12'h008, 0);
    chk(rd, 32'h15a7);
    apb(1'b0, 12'h00c, 0);
    chk(e, 1'b1);
    apb(1'b1, 12'h000, 32'hff);
    seq(3'h1, 11'h000);
    settle();
    chk(program_counter_out, 32'h1600);
    $display("regs done");
  endtask : t_regs

  task t_stack;
    apb(1'b1, 12'h004, 32'h1a);
    seq(3'h2, 11'h123);
    settle();
    chk(program_counter_out, 32'h1923);
    for (i = 0; i < 9; i++)
      seq(3'h3, 11'h100 + 11'(i));
    settle();
    for (i = 8; i >= 0; i--)
    begin
      seq(3'h4, 11'h000);
      settle();
      epc = {2'b11, 11'h100 + 11'((i == 0) ? 8 : i) - 11'h001};
      chk(program_counter_out, epc);
    end
    chk(high_address_holding_latch_out, 5'h1a);
    $display("stack done");
  endtask : t_stack

  task t_irq;
    seq(3'h5, 11'h000);
    settle();
    chk(program_counter_out, 32'h0004);
    seq(3'h4, 11'h000);
    settle();
    chk(program_counter_out, epc);
    seq(3'h3, 11'h055);
    seq(3'h4, 11'h000);
    settle();
    chk(program_counter_out, epc);
    $display("irq done");
  endtask : t_irq

  // Reset in mid-run, then the first request right after release
  task t_reset;
    srst_in <= 1'b1;
    @(posedge core_clk_in);
    srst_in <= 1'b0;
    @(posedge core_clk_in);
    chk(program_counter_out, 0);
    seq(3'h1, 11'h000);
    settle();
    chk(program_counter_out, 32'h0001);
    $display("reset done");
  endtask : t_reset

  // Core data path writes the latch, then the low byte
  task t_core;
    core_latch_wr_in   <= 1'b1;
    core_latch_data_in <= 5'h0c;
    @(posedge core_clk_in);
    core_latch_wr_in   <= 1'b0;
    core_low_wr_in     <= 1'b1;
    core_low_data_in   <= 8'h3c;
    @(posedge core_clk_in);
    core_low_wr_in     <= 1'b0;
    @(posedge core_clk_in);
    chk(program_counter_out, 32'h0c3c);
    chk(high_address_holding_latch_out, 5'h0c);
    $display("core done");
  endtask : t_core

  task end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  initial
  begin
    srst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    op = 3'h0;
    tgt = 11'h000;
    core_low_wr_in = 1'b0;
    core_low_data_in = 8'h00;
    core_latch_wr_in = 1'b0;
    core_latch_data_in = 5'h00;
    repeat (3) @(posedge core_clk_in);
    srst_in <= 1'b0;
    t_regs();
    t_stack();
    t_irq();
    t_reset();
    t_core();
    end_sim();
  end
endmodule : tb

`default_nettype wire
